// ### src/adda_ctrl.sv
// Bus address decode, function control register and oscillator control
`timescale 1ns/1ps

// What this block does
// - Answer one 7-bit address picked by how the three straps are tied.
// - Second byte of a write transfer loads the function control register.
// - Upper half holds analog output enable and input configuration.
// - Lower half selects one channel of those the configuration offers.
// - With auto-increment set, channel advances after each finished conversion.
// - A channel beyond the configuration's range becomes the highest existing one.
// - Auto-increment wraps from the highest channel back to channel zero.
// - Power-on clears every control bit.
// - After power-on, converter and oscillator off, analog output high impedance.
// - Control bits 7 and 3 both set halve the conversion clock.
// - Bit 7 clear with bit 3 set shows oscillator divided by four.
// - Otherwise the oscillator observation output stays low.
// - A stop halts the oscillator unless analog output is enabled.
module adda_ctrl
  import adda_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_clk,
  input wire logic scl_pin,
  input wire logic sda_pin_i,
  output logic sda_pin_o,
  output logic sda_pin_oe_n,
  input wire logic strap_pin_low,
  input wire logic strap_pin_mid,
  input wire logic strap_pin_high,
  input wire logic clock_source_select,
  input wire logic conversion_done,
  output logic [7:0] function_control,
  output logic [1:0] channel_select,
  output logic analog_output_pin_en,
  output logic conversion_request,
  output logic osc_run,
  output logic [6:0] device_address,
  output logic osc_pin_o,
  output logic osc_pin_oe_n,
  output logic conv_clk_en
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [pin_count-1:0] pin_raw;
  logic [pin_count-1:0] pin_s1_q;
  logic [pin_count-1:0] pin_s2_q;
  logic [pin_count-1:0] pin_s3_q;
  logic [pin_count-1:0] pin_f_q;
  logic [pin_count-1:0] pin_p_q;

  assign pin_raw = {clock_source_select, strap_pin_high, strap_pin_mid, strap_pin_low,
                    sda_pin_i, scl_pin};

  genvar gi;
  generate
    for (gi = 0; gi < pin_count; gi++) begin : g_pin_sync
      always_ff @(posedge clk) begin
        pin_s1_q[gi] <= pin_raw[gi];
        pin_s2_q[gi] <= pin_s1_q[gi];
        pin_s3_q[gi] <= pin_s2_q[gi];
      end
      // Idle bus lines are high; a change counts once two stages agree
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_f_q[gi] <= 1'b1;
          pin_p_q[gi] <= 1'b1;
        end else begin
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_f_q[gi] <= pin_s3_q[gi];
          end
          pin_p_q[gi] <= pin_f_q[gi];
        end
      end
    end
  endgenerate

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic lines_steady;

  assign scl_f = pin_f_q[pin_scl];
  assign sda_f = pin_f_q[pin_sda];
  assign scl_rise = scl_f && !pin_p_q[pin_scl];
  assign scl_fall = !scl_f && pin_p_q[pin_scl];
  assign bus_start = scl_f && pin_p_q[pin_scl] && !sda_f && pin_p_q[pin_sda];
  assign bus_stop = scl_f && pin_p_q[pin_scl] && sda_f && !pin_p_q[pin_sda];
  assign lines_steady = (scl_f == pin_p_q[pin_scl]) && (sda_f == pin_p_q[pin_sda]);

  // ---------------------------------------------------------------------
  // Strap sensing and address decode
  // ---------------------------------------------------------------------
  logic [2:0] mis_scl_q;
  logic [2:0] mis_sda_q;
  logic [2:0] seen_lo_q;
  logic [2:0] seen_hi_q;
  logic [1:0] strap_code_q [3];
  logic [6:0] own_addr_q;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_strap
      // Straps are only compared while the bus lines hold still, so sampling
      // skew on a line edge is never taken for a mismatch
      always_ff @(posedge clk) begin
        if (rst) begin
          mis_scl_q[gi] <= 1'b0;
          mis_sda_q[gi] <= 1'b0;
          seen_lo_q[gi] <= 1'b0;
          seen_hi_q[gi] <= 1'b0;
        end else if (lines_steady && (pin_f_q[pin_strap0+gi] == pin_p_q[pin_strap0+gi])) begin
          if (pin_f_q[pin_strap0+gi] != scl_f) begin
            mis_scl_q[gi] <= 1'b1;
          end
          if (pin_f_q[pin_strap0+gi] != sda_f) begin
            mis_sda_q[gi] <= 1'b1;
          end
          if (pin_f_q[pin_strap0+gi]) begin
            seen_hi_q[gi] <= 1'b1;
          end else begin
            seen_lo_q[gi] <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          strap_code_q[gi] <= strap_vdd;
        end else if (!mis_sda_q[gi] && seen_lo_q[gi] && seen_hi_q[gi]) begin
          strap_code_q[gi] <= strap_sda;
        end else if (!mis_scl_q[gi] && seen_lo_q[gi] && seen_hi_q[gi]) begin
          strap_code_q[gi] <= strap_scl;
        end else begin
          strap_code_q[gi] <= pin_f_q[pin_strap0+gi] ? strap_vdd : strap_vss;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      own_addr_q <= base_address;
    end else begin
      own_addr_q <= base_address +
        {1'b0, addr_index_table[{strap_code_q[2], strap_code_q[1], strap_code_q[0]}]};
    end
  end

  // ---------------------------------------------------------------------
  // Link engine
  // ---------------------------------------------------------------------
  link_state_type state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_idx_q;
  logic rw_q;
  logic addr_match;
  logic ctrl_we;
  logic addr_miss;

  assign addr_match = (shift_q[7:1] == own_addr_q);
  assign ctrl_we = (state_q == st_rx) && scl_fall && (bit_cnt_q == bits_per_byte) &&
                   (byte_idx_q == byte_idx_ctrl) && !rw_q;
  assign addr_miss = (state_q == st_rx) && scl_fall && (bit_cnt_q == bits_per_byte) &&
                     (byte_idx_q == byte_idx_addr) && !addr_match;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= st_idle;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= byte_idx_addr;
      rw_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= st_rx;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= byte_idx_addr;
    end else if (bus_stop) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_rx: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && (bit_cnt_q == bits_per_byte)) begin
            bit_cnt_q <= 4'h0;
            if (byte_idx_q == byte_idx_addr) begin
              rw_q <= shift_q[0];
              state_q <= addr_match ? st_ack : st_skip;
            end else begin
              state_q <= st_ack;
            end
            if (byte_idx_q != byte_idx_data) begin
              byte_idx_q <= byte_idx_q + 2'h1;
            end
          end
        end
        st_ack: begin
          // Read data is sent by the converter datapath, so this end lets go
          if (scl_fall) begin
            state_q <= rw_q ? st_skip : st_rx;
          end
        end
        st_skip: begin
          state_q <= st_skip;
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // Acknowledge is driven from the clock fall that ends a byte to the next
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_pin_o <= 1'b0;
      sda_pin_oe_n <= 1'b1;
    end else begin
      sda_pin_o <= 1'b0;
      if (bus_start || bus_stop) begin
        sda_pin_oe_n <= 1'b1;
      end else if ((state_q == st_rx) && scl_fall && (bit_cnt_q == bits_per_byte) &&
                   ((byte_idx_q != byte_idx_addr) || addr_match)) begin
        sda_pin_oe_n <= 1'b0;
      end else if ((state_q == st_ack) && scl_fall) begin
        sda_pin_oe_n <= 1'b1;
      end
    end
  end

  // A conversion starts at the trailing edge of a read address acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      conversion_request <= 1'b0;
    end else begin
      conversion_request <= (state_q == st_ack) && scl_fall && rw_q && !bus_start && !bus_stop;
    end
  end

  // ---------------------------------------------------------------------
  // Function control register and channel selection
  // ---------------------------------------------------------------------
  logic [2:0] done_tgl_s_q;
  logic conv_done_pulse;
  logic [1:0] new_chan_max;
  logic [1:0] cur_chan_max;
  logic done_tgl_q;

  assign conv_done_pulse = done_tgl_s_q[1] ^ done_tgl_s_q[2];
  assign new_chan_max = chan_max_table[shift_q[ctrl_mode_msb:ctrl_mode_lsb]];
  assign cur_chan_max = chan_max_table[function_control[ctrl_mode_msb:ctrl_mode_lsb]];

  always_ff @(posedge clk) begin
    if (rst) begin
      function_control <= control_reset;
    end else if (ctrl_we) begin
      function_control <= shift_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      channel_select <= control_reset[ctrl_chan_msb:ctrl_chan_lsb];
    end else if (ctrl_we) begin
      // A new control byte wins over a conversion ending in the same cycle
      if (shift_q[ctrl_chan_msb:ctrl_chan_lsb] > new_chan_max) begin
        channel_select <= new_chan_max;
      end else begin
        channel_select <= shift_q[ctrl_chan_msb:ctrl_chan_lsb];
      end
    end else if (conv_done_pulse && function_control[ctrl_autoinc_bit]) begin
      if (channel_select >= cur_chan_max) begin
        channel_select <= 2'h0;
      end else begin
        channel_select <= channel_select + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      analog_output_pin_en <= 1'b0;
    end else begin
      analog_output_pin_en <= function_control[ctrl_aoe_bit];
    end
  end

  // Oscillator runs from a start; a missed address or a stop halts it unless
  // the analog output keeps it alive
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_run <= 1'b0;
    end else if (bus_start) begin
      osc_run <= 1'b1;
    end else if (bus_stop || addr_miss) begin
      osc_run <= function_control[ctrl_aoe_bit];
    end else if (function_control[ctrl_aoe_bit]) begin
      osc_run <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      device_address <= base_address;
    end else begin
      device_address <= own_addr_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_tgl_s_q <= 3'h0;
    end else begin
      done_tgl_s_q <= {done_tgl_s_q[1:0], done_tgl_q};
    end
  end

  // ---------------------------------------------------------------------
  // Oscillator domain
  // ---------------------------------------------------------------------
  logic [1:0] osc_rst_s_q;
  logic osc_rst;
  logic [3:0] lvl_src;
  logic [3:0] lvl_s1_q;
  logic [3:0] lvl_s2_q;
  logic [3:0] lvl_s3_q;
  logic [3:0] lvl_q;
  logic [1:0] div_q;

  // Levels: run, halve observe, external clock source
  assign lvl_src = {pin_f_q[pin_ext],
                    !function_control[ctrl_osc_hi_bit] && function_control[ctrl_osc_lo_bit],
                    function_control[ctrl_osc_hi_bit] && function_control[ctrl_osc_lo_bit],
                    osc_run};
  assign osc_rst = osc_rst_s_q[1];

  always_ff @(posedge osc_clk) begin
    osc_rst_s_q <= {osc_rst_s_q[0], rst};
    lvl_s1_q <= lvl_src;
    lvl_s2_q <= lvl_s1_q;
    lvl_s3_q <= lvl_s2_q;
  end

  // A level counts once the second and third stages agree, else it holds
  always_ff @(posedge osc_clk) begin
    lvl_q <= (lvl_s2_q & lvl_s3_q) | (lvl_q & (lvl_s2_q | lvl_s3_q));
  end

  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      div_q <= 2'h0;
    end else if (lvl_q[0]) begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      conv_clk_en <= 1'b0;
    end else if (lvl_q[1]) begin
      conv_clk_en <= lvl_q[0] && div_q[0];
    end else begin
      conv_clk_en <= lvl_q[0];
    end
  end

  // External source leaves the pin floating so the clock can be fed in
  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      osc_pin_o <= 1'b0;
      osc_pin_oe_n <= 1'b1;
    end else begin
      osc_pin_oe_n <= lvl_q[3];
      if (lvl_q[2] && lvl_q[0]) begin
        osc_pin_o <= div_q[1];
      end else begin
        osc_pin_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      done_tgl_q <= 1'b0;
    end else if (conversion_done) begin
      done_tgl_q <= !done_tgl_q;
    end
  end

endmodule // adda_ctrl

// ### src/adda_ctrl_pkg.sv
// Constants, tables and types shared by the bus front end of the converter
package adda_ctrl_pkg;

  // ---------------------------------------------------------------------
  // Pin synchroniser and strap coding
  // ---------------------------------------------------------------------
  localparam int pin_count = 6;
  localparam int pin_scl = 0;
  localparam int pin_sda = 1;
  localparam int pin_strap0 = 2;
  localparam int pin_ext = 5;
  localparam logic [1:0] strap_vss = 2'h0;
  localparam logic [1:0] strap_vdd = 2'h1;
  localparam logic [1:0] strap_sda = 2'h2;
  localparam logic [1:0] strap_scl = 2'h3;

  // ---------------------------------------------------------------------
  // Address map: strap code {high, mid, low} to position above the base
  // ---------------------------------------------------------------------
  localparam logic [6:0] base_address = 7'h20;
  localparam logic [5:0] addr_index_table [64] = '{
    6'h28, 6'h29, 6'h00, 6'h14, 6'h2a, 6'h2b, 6'h01, 6'h15,
    6'h04, 6'h05, 6'h0c, 6'h30, 6'h18, 6'h19, 6'h26, 6'h20,
    6'h2c, 6'h2d, 6'h02, 6'h16, 6'h2e, 6'h2f, 6'h03, 6'h17,
    6'h06, 6'h07, 6'h0d, 6'h31, 6'h1a, 6'h1b, 6'h27, 6'h21,
    6'h08, 6'h09, 6'h0e, 6'h36, 6'h0a, 6'h0b, 6'h0f, 6'h37,
    6'h10, 6'h11, 6'h12, 6'h3f, 6'h34, 6'h35, 6'h3e, 6'h3a,
    6'h1c, 6'h1d, 6'h38, 6'h22, 6'h1e, 6'h1f, 6'h39, 6'h23,
    6'h32, 6'h33, 6'h3d, 6'h3b, 6'h24, 6'h25, 6'h3c, 6'h13
  };

  // ---------------------------------------------------------------------
  // Function control register layout
  // ---------------------------------------------------------------------
  localparam logic [7:0] control_reset = 8'h00;
  localparam int ctrl_osc_hi_bit = 7;
  localparam int ctrl_aoe_bit = 6;
  localparam int ctrl_mode_msb = 5;
  localparam int ctrl_mode_lsb = 4;
  localparam int ctrl_osc_lo_bit = 3;
  localparam int ctrl_autoinc_bit = 2;
  localparam int ctrl_chan_msb = 1;
  localparam int ctrl_chan_lsb = 0;
  // Highest existing channel for each input configuration
  localparam logic [1:0] chan_max_table [4] = '{2'h3, 2'h2, 2'h2, 2'h1};

  // ---------------------------------------------------------------------
  // Link engine
  // ---------------------------------------------------------------------
  localparam logic [3:0] bits_per_byte = 4'h8;
  localparam logic [1:0] byte_idx_addr = 2'h0;
  localparam logic [1:0] byte_idx_ctrl = 2'h1;
  localparam logic [1:0] byte_idx_data = 2'h2;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_rx = 2'b01,
    st_ack = 2'b11,
    st_skip = 2'b10
  } link_state_type;

endpackage

// ### test/adda_ctrl_checker.sv
// Port-level assertions for the converter bus front end
`timescale 1ns/1ps
module adda_ctrl_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_clk,
  input wire logic scl_pin,
  input wire logic sda_pin_i,
  input wire logic sda_pin_oe_n,
  input wire logic [7:0] function_control,
  input wire logic [1:0] channel_select,
  input wire logic analog_output_pin_en,
  input wire logic conversion_request,
  input wire logic osc_run,
  input wire logic osc_pin_o,
  input wire logic conv_clk_en
);
  logic [1:0] mode;
  logic [1:0] top_ch;
  logic [1:0] want_ch;
  logic observe;
  logic halved;
  assign mode = function_control[5:4];
  assign top_ch = (mode == 2'h0) ? 2'h3 : (mode == 2'h3) ? 2'h1 : 2'h2;
  assign want_ch = (function_control[1:0] > top_ch) ? top_ch : function_control[1:0];
  assign observe = !function_control[7] && function_control[3];
  assign halved = function_control[7] && function_control[3];
  // --------
  // Control side
  // --------
  // Two quiet cycles keep a fresh write apart from a conversion step
  sequence ctrl_calm;
    $stable(function_control) ##1 $stable(function_control);
  endsequence
  reset_clear_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> function_control == 8'h00 && !analog_output_pin_en && !osc_run)
    else $error("control not clear");
  clamp_a: assert property (@(posedge clk) disable iff (rst)
    $changed(function_control) |=> channel_select == want_ch)
    else $error("channel not clamped");
  analog_output_pin_en_a: assert property (@(posedge clk) disable iff (rst)
    $changed(function_control) |-> ##2 analog_output_pin_en == function_control[6])
    else $error("output enable wrong");
  no_step_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_calm ##0 !function_control[2] |-> $stable(channel_select))
    else $error("channel moved");
  wrap_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_calm ##0 (function_control[2] && $changed(channel_select)) |->
    channel_select == (($past(channel_select) >= top_ch) ? 2'h0 : $past(channel_select) + 2'h1))
    else $error("wrong channel step");
  ack_hold_a: assert property (@(posedge clk) disable iff (rst)
    $fell(sda_pin_oe_n) |=> !sda_pin_oe_n [*8])
    else $error("ack too short");
  conv_req_a: assert property (@(posedge clk) disable iff (rst)
    $rose(conversion_request) |=> !conversion_request)
    else $error("request too long");
  stop_halt_a: assert property (@(posedge clk) disable iff (rst)
    scl_pin && $rose(sda_pin_i) |-> ##[6:12] osc_run == function_control[6])
    else $error("oscillator wrong after stop");
  // --------
  // Oscillator side
  // --------
  halve_a: assert property (@(posedge osc_clk) disable iff (rst)
    halved [*6] ##0 conv_clk_en |=> !conv_clk_en)
    else $error("clock not halved");
  observe_off_a: assert property (@(posedge osc_clk) disable iff (rst)
    !observe [*6] |-> !osc_pin_o)
    else $error("observe output not low");
  observe_div_a: assert property (@(posedge osc_clk) disable iff (rst)
    $fell(osc_pin_o) ##0 observe |=> (!osc_pin_o || !observe) ##1 (osc_pin_o || !observe))
    else $error("observe output not divided by four");
endmodule // adda_ctrl_checker

// ### test/i2c_master_model.sv
// Bus master model driving clock and data toward the converter front end
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_m
);
  // Half bit time in clk cycles; the bench slows it for the halved oscillator
  int half = 20;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold;
    repeat (half) @(negedge clk);
  endtask
  // Data moves well after the clock fall, so no edge reads as start or stop
  task automatic low_gap;
    repeat (8) @(negedge clk);
  endtask
  task automatic bus_start;
    sda_m = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_m = 1'b0;
    hold();
    scl = 1'b0;
    low_gap();
  endtask
  task automatic bus_stop;
    sda_m = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_m = 1'b1;
    hold();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m = b[i];
      hold();
      scl = 1'b1;
      hold();
      scl = 1'b0;
      low_gap();
    end
    sda_m = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    ack = !sda_bus;
    scl = 1'b0;
    low_gap();
  endtask
endmodule // i2c_master_model

// ### test/tb_adda_ctrl.sv
// Self-checking bench for the converter bus front end
`timescale 1ns/1ps
module tb_adda_ctrl;
  import adda_ctrl_pkg::*;
  // --------
  // Clocks, bus wire and straps
  // --------
  logic clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst = 1'b1;
  logic conversion_done = 1'b0;
  logic clock_source_select = 1'b0;
  logic scl, sda_m, sda_bus, sda_pin_o, sda_pin_oe_n, s_lo, s_mid, s_hi, ack;
  logic aoe, conv_req, osc_run, osc_pin_o, osc_oe_n, conv_en;
  logic [1:0] c_lo = 2'h0;
  logic [1:0] c_mid = 2'h0;
  logic [1:0] c_hi = 2'h0;
  logic [1:0] ch;
  logic [7:0] fc, pat, c;
  logic [6:0] dev_adr, a;
  logic [1:0] maxc [4] = '{2'h3, 2'h2, 2'h2, 2'h1};
  logic [12:0] cfg [4] = '{{strap_sda, strap_sda, strap_scl, 7'h5f},
    {strap_vdd, strap_vdd, strap_vdd, 7'h4f}, {strap_scl, strap_scl, strap_scl, 7'h33},
    {strap_vss, strap_vss, strap_sda, 7'h20}};
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_req = 0;
  int r;
  always #4 clk = ~clk;
  initial begin
    #2.3;
    forever #7.5 osc_clk = ~osc_clk;
  end
  function automatic logic pick(input logic [1:0] s, input logic cl, input logic da);
    return (s == strap_vss) ? 1'b0 : (s == strap_vdd) ? 1'b1 : (s == strap_sda) ? da : cl;
  endfunction
  // Open drain: the device only ever pulls low, the pull-up wins otherwise
  assign sda_bus = sda_m & (sda_pin_oe_n | sda_pin_o);
  assign s_lo = pick(c_lo, scl, sda_bus);
  assign s_mid = pick(c_mid, scl, sda_bus);
  assign s_hi = pick(c_hi, scl, sda_bus);
  i2c_master_model i_master (.clk(clk), .sda_bus(sda_bus), .scl(scl), .sda_m(sda_m));
  adda_ctrl i_dut (.clk(clk), .rst(rst), .osc_clk(osc_clk), .scl_pin(scl),
    .sda_pin_i(sda_bus), .sda_pin_o(sda_pin_o), .sda_pin_oe_n(sda_pin_oe_n),
    .strap_pin_low(s_lo), .strap_pin_mid(s_mid), .strap_pin_high(s_hi),
    .clock_source_select(clock_source_select), .conversion_done(conversion_done),
    .function_control(fc), .channel_select(ch), .analog_output_pin_en(aoe),
    .conversion_request(conv_req), .osc_run(osc_run), .device_address(dev_adr),
    .osc_pin_o(osc_pin_o), .osc_pin_oe_n(osc_oe_n), .conv_clk_en(conv_en));
  // --------
  // Tasks
  // --------
  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv_req === 1'b1) n_req <= n_req + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] adr, input logic [7:0] v);
    logic k;
    i_master.bus_start();
    i_master.put_byte({adr, 1'b0}, ack);
    i_master.put_byte(v, k);
    i_master.bus_stop();
    chk("write ack", 8'h03, {6'h0, ack, k});
  endtask
  task automatic grab(input bit sel);
    repeat (8) begin
      @(posedge osc_clk);
      #1 pat = {pat[6:0], sel ? conv_en : osc_pin_o};
    end
  endtask
  task automatic conv_pulse;
    @(negedge osc_clk) conversion_done = 1'b1;
    @(negedge osc_clk) conversion_done = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst = 1'b1;
      {c_hi, c_mid, c_lo, a} = cfg[i];
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      chk("control", 8'h00, fc);
      chk("outputs", 8'h00, {5'h0, aoe, osc_run, osc_pin_o});
      i_master.bus_start();
      i_master.put_byte(8'hfe, ack);
      i_master.bus_stop();
      chk("foreign ack", 8'h00, {7'h0, ack});
      chk("address", {1'b0, a}, {1'b0, dev_adr});
      wr(a, 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      c = {1'b0, k[0], k[1:0], 4'h3};
      wr(a, c);
      chk("control", c, fc);
      chk("channel", {6'h0, maxc[k]}, {6'h0, ch});
      chk("output enable", {7'h0, c[6]}, {7'h0, aoe});
    end
    wr(a, 8'h46);
    conv_pulse();
    chk("channel", 8'h03, {6'h0, ch});
    conv_pulse();
    chk("channel", 8'h00, {6'h0, ch});
    wr(a, 8'h42);
    conv_pulse();
    chk("channel", 8'h02, {6'h0, ch});
    r = n_req;
    i_master.bus_start();
    i_master.put_byte({a, 1'b1}, ack);
    i_master.bus_stop();
    chk("read", 8'h11, {3'h0, ack, 4'(n_req - r)});
    wr(a, 8'h48);
    @(posedge osc_pin_o);
    grab(1'b0);
    chk("observe", 8'h99, pat);
    wr(a, 8'h40);
    grab(1'b0);
    chk("observe off", 8'h00, pat);
    grab(1'b1);
    chk("full rate", 8'hff, pat);
    i_master.half = 160;
    wr(a, 8'hc8);
    i_master.half = 20;
    grab(1'b1);
    chk("halved", 8'h01, {7'h0, pat == 8'haa || pat == 8'h55});
    wr(a, 8'h00);
    chk("osc stop", 8'h00, {7'h0, osc_run});
    i_master.bus_start();
    chk("osc start", 8'h01, {7'h0, osc_run});
    i_master.bus_stop();
    chk("osc stop", 8'h00, {7'h0, osc_run});
    clock_source_select = 1'b1;
    repeat (20) @(negedge clk);
    chk("osc pin enable", 8'h01, {7'h0, osc_oe_n});
    clock_source_select = 1'b0;
    repeat (20) @(negedge clk);
    chk("osc pin enable", 8'h00, {7'h0, osc_oe_n});
    test_done();
  end
endmodule // tb_adda_ctrl

bind adda_ctrl adda_ctrl_checker i_chk (.clk, .rst, .osc_clk, .scl_pin, .sda_pin_i,
  .sda_pin_oe_n, .function_control, .channel_select, .analog_output_pin_en,
  .conversion_request, .osc_run, .osc_pin_o, .conv_clk_en);
